/* File: core/edge_pulse_filter.v */
// optional noise rejection and edge selection for one external count input
`timescale 1ns/1ps
`include "port_ctrl_defs.vh"

module edge_pulse_filter #(
	parameter FILT_LEN = 4
) (
	input wire pclk,
	input wire presetn,
	input wire pulse_in,
	input wire noise_reject,
	input wire falling_edge,
	output reg count_pulse
);
	reg [FILT_LEN-1:0] hist_q;
	reg level_q;
	reg filt_level;
	reg sel_level;

	// filtered level changes only after FILT_LEN matching samples
	always @* begin
		filt_level = level_q;
		if (&hist_q) begin
			filt_level = 1'b1;
		end else if (~|hist_q) begin
			filt_level = 1'b0;
		end
		sel_level = noise_reject ? filt_level : hist_q[0];
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_q <= {FILT_LEN{1'b0}};
			level_q <= 1'b0;
			count_pulse <= 1'b0;
		end else begin
			hist_q <= {hist_q[FILT_LEN-2:0], pulse_in};
			level_q <= sel_level;
			// polarity 0 counts rising edges, 1 falling
			count_pulse <= falling_edge ? (level_q & ~sel_level) : (~level_q & sel_level);
		end
	end
endmodule

/* File: core/key_irq_bank.v */
// sticky key interrupt flags with write-one-to-clear; mask_bits is not applied here
`timescale 1ns/1ps
`include "port_ctrl_defs.vh"

module key_irq_bank #(
	parameter N = 8
) (
	input wire pclk,
	input wire presetn,
	input wire [N-1:0] key_in,
	input wire [N-1:0] mask_bits,
	input wire [N-1:0] clear_bits,
	output reg [N-1:0] flags
);
	reg [N-1:0] key_prev_q;
	wire [N-1:0] key_event;

	// a rising key level is the interrupt condition
	assign key_event = key_in & ~key_prev_q;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_prev_q <= {N{1'b0}};
			flags <= {N{1'b0}};
		end else begin
			key_prev_q <= key_in;
			// set wins over a clear in the same cycle
			flags <= (flags & ~clear_bits) | key_event;
		end
	end
endmodule

/* File: core/port_ctrl_defs.vh */
// register offsets, field positions and reset values of the port control bank
`ifndef PORT_CTRL_DEFS_VH
`define PORT_CTRL_DEFS_VH

`define PAIR0_MODE_ADDR 16'hff80
`define PAIR0_OUT_ADDR 16'hff81
`define PAIR1_MODE_ADDR 16'hff90
`define PAIR1_OUT_ADDR 16'hff91
`define PAIR2_MODE_ADDR 16'hffa0
`define PAIR2_OUT_ADDR 16'hffa1
`define PAIR3_MODE_ADDR 16'hffb0
`define PAIR3_OUT_ADDR 16'hffb1
`define KEY0_MASK_ADDR 16'hffeb
`define KEY1_MASK_ADDR 16'hffec
`define KEY0_FLAG_ADDR 16'hfffb
`define KEY1_FLAG_ADDR 16'hfffc

// register index to byte address
`define IDX_SHIFT 2

// mode register fields
`define MODE_EDGE_POL 0
`define MODE_NOISE_REJ 1
`define MODE_EVENT_CNT 2
`define MODE_CHAIN16 3
// output register fields
`define OUT_ENABLE 0
`define OUT_SRC_SEL 1
`define OUT_PWM_EVEN 2
`define OUT_PWM_ODD 3

`define REG_RESET 4'h0
`define NOISE_FILT_LEN 4'h4

`endif

/* File: core/port_timer_key_irq_ctrl.v */
// timer pair configuration and key interrupt control bank behind APB
`timescale 1ns/1ps
`include "port_ctrl_defs.vh"

// Overview of operation
// - chain bit 1 joins a timer pair into 16 bits, else two 8-bit timers
// - counter-mode bit 1 makes the even timer count external pulses
// - select bit 1 applies noise rejection to the event input
// - polarity bit picks counting edge; 0 is the default (rising) edge
// - per-timer pwm select bit chooses pwm or normal output
// - source bit 1 drives pair pin from odd timer, 0 from even
// - output-control bit enables the pair's timer output pin
// - eight key interrupt mask bits, 1 enables, 0 masks
// - one sticky flag per key, reads 1 after the key event
// - writing 1 clears a flag; writing 0 leaves it
// - second group bit 3 maps to highest pin of second key port
// - reset clears every configuration, mask and flag bit
// - event mode claims a dedicated pin as external count clock
module port_timer_key_irq_ctrl #(
	parameter NPAIR = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [3:0] key_port0,
	input wire [3:0] key_port1,
	input wire [NPAIR-1:0] event_pin,
	input wire [2*NPAIR-1:0] timer_out,
	input wire [2*NPAIR-1:0] timer_pwm,
	output reg [NPAIR-1:0] chain_16bit,
	output reg [NPAIR-1:0] event_count_pulse,
	output reg [NPAIR-1:0] event_pin_claimed,
	output reg [NPAIR-1:0] timer_out_pin,
	output reg [NPAIR-1:0] timer_out_pin_oe,
	output reg key_irq
);
	// ***********************************************************
	// register decode
	// ***********************************************************
	localparam SEL_NONE = 4'h0;
	localparam SEL_MODE = 4'h1;
	localparam SEL_OUT = 4'h2;
	localparam SEL_KMASK = 4'h3;
	localparam SEL_KFLAG = 4'h4;

	reg [3:0] mode_q [0:NPAIR-1];
	reg [3:0] out_q [0:NPAIR-1];
	reg [3:0] key0_mask_q;
	reg [3:0] key1_mask_q;
	reg access_q;
	wire [7:0] key_flags;
	wire [7:0] key_clear;
	wire [NPAIR-1:0] filt_pulse;
	wire wr_en;
	wire rd_en;
	reg [3:0] sel_kind;
	reg [1:0] sel_idx;
	reg [3:0] rd_data;

	// printed offsets are not all word aligned: byte address is index times four
	function [3:0] decode_kind;
		input [17:0] addr;
		begin
			decode_kind = SEL_NONE;
			if (addr[1:0] == 2'b00) begin
				case (addr[17:`IDX_SHIFT])
				`PAIR0_MODE_ADDR, `PAIR1_MODE_ADDR, `PAIR2_MODE_ADDR, `PAIR3_MODE_ADDR:
					decode_kind = SEL_MODE;
				`PAIR0_OUT_ADDR, `PAIR1_OUT_ADDR, `PAIR2_OUT_ADDR, `PAIR3_OUT_ADDR:
					decode_kind = SEL_OUT;
				`KEY0_MASK_ADDR, `KEY1_MASK_ADDR:
					decode_kind = SEL_KMASK;
				`KEY0_FLAG_ADDR, `KEY1_FLAG_ADDR:
					decode_kind = SEL_KFLAG;
				default:
					decode_kind = SEL_NONE;
				endcase
			end
		end
	endfunction

	// pair index sits in address nibble of the index; key group flips index bits 2:0
	function [1:0] decode_idx;
		input [17:0] addr;
		reg [15:0] idx;
		begin
			idx = addr[17:`IDX_SHIFT];
			case (idx)
			`PAIR1_MODE_ADDR, `PAIR1_OUT_ADDR, `KEY1_MASK_ADDR, `KEY1_FLAG_ADDR:
				decode_idx = 2'h1;
			`PAIR2_MODE_ADDR, `PAIR2_OUT_ADDR:
				decode_idx = 2'h2;
			`PAIR3_MODE_ADDR, `PAIR3_OUT_ADDR:
				decode_idx = 2'h3;
			default:
				decode_idx = 2'h0;
			endcase
		end
	endfunction

	always @* begin
		sel_kind = decode_kind(paddr);
		sel_idx = decode_idx(paddr);
	end

	// one wait-free access phase: pready rises in the first access cycle
	assign wr_en = psel & penable & pwrite & ~access_q & (sel_kind != SEL_NONE);
	assign rd_en = psel & ~penable;

	// ***********************************************************
	// configuration registers
	// ***********************************************************
	genvar g;
	generate
		for (g = 0; g < NPAIR; g = g + 1) begin : pair
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mode_q[g] <= `REG_RESET;
					out_q[g] <= `REG_RESET;
				end else if (wr_en && sel_idx == g) begin
					if (sel_kind == SEL_MODE) begin
						mode_q[g] <= pwdata[3:0];
					end
					if (sel_kind == SEL_OUT) begin
						out_q[g] <= pwdata[3:0];
					end
				end
			end

			edge_pulse_filter #(
				.FILT_LEN(`NOISE_FILT_LEN)
			) u_filt (
				.pclk(pclk),
				.presetn(presetn),
				.pulse_in(event_pin[g]),
				.noise_reject(mode_q[g][`MODE_NOISE_REJ]),
				.falling_edge(mode_q[g][`MODE_EDGE_POL]),
				.count_pulse(filt_pulse[g])
			);
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key0_mask_q <= `REG_RESET;
			key1_mask_q <= `REG_RESET;
		end else if (wr_en && sel_kind == SEL_KMASK) begin
			if (sel_idx == 2'h0) begin
				key0_mask_q <= pwdata[3:0];
			end else begin
				key1_mask_q <= pwdata[3:0];
			end
		end
	end

	// ***********************************************************
	// key interrupt flags
	// ***********************************************************
	assign key_clear = (wr_en && sel_kind == SEL_KFLAG) ?
		(sel_idx == 2'h0 ? {4'h0, pwdata[3:0]} : {pwdata[3:0], 4'h0}) : 8'h00;

	key_irq_bank #(
		.N(8)
	) u_keys (
		.pclk(pclk),
		.presetn(presetn),
		.key_in({key_port1, key_port0}),
		.mask_bits({key1_mask_q, key0_mask_q}),
		.clear_bits(key_clear),
		.flags(key_flags)
	);

	// ***********************************************************
	// read path and bus answer
	// ***********************************************************
	always @* begin
		case (sel_kind)
		SEL_MODE:
			rd_data = mode_q[sel_idx];
		SEL_OUT:
			rd_data = out_q[sel_idx];
		SEL_KMASK:
			rd_data = (sel_idx == 2'h0) ? key0_mask_q : key1_mask_q;
		SEL_KFLAG:
			rd_data = (sel_idx == 2'h0) ? key_flags[3:0] : key_flags[7:4];
		default:
			rd_data = 4'h0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_q <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			access_q <= psel & penable & ~access_q;
			pready <= psel & ~penable;
			// error stands only beside pready, never left over for the next cycle
			pslverr <= rd_en & (sel_kind == SEL_NONE);
			if (rd_en) begin
				prdata <= pwrite ? 32'h0000_0000 : {28'h0000000, rd_data};
			end
		end
	end

	// ***********************************************************
	// timer pin, mode and key interrupt outputs
	// ***********************************************************
	integer i;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_16bit <= {NPAIR{1'b0}};
			event_count_pulse <= {NPAIR{1'b0}};
			event_pin_claimed <= {NPAIR{1'b0}};
			timer_out_pin <= {NPAIR{1'b0}};
			timer_out_pin_oe <= {NPAIR{1'b0}};
			key_irq <= 1'b0;
		end else begin
			for (i = 0; i < NPAIR; i = i + 1) begin
				chain_16bit[i] <= mode_q[i][`MODE_CHAIN16];
				// pulses reach the counter only in event mode
				event_count_pulse[i] <= filt_pulse[i] & mode_q[i][`MODE_EVENT_CNT];
				event_pin_claimed[i] <= mode_q[i][`MODE_EVENT_CNT];
				if (out_q[i][`OUT_SRC_SEL]) begin
					timer_out_pin[i] <= out_q[i][`OUT_PWM_ODD] ?
						timer_pwm[2*i+1] : timer_out[2*i+1];
				end else begin
					timer_out_pin[i] <= out_q[i][`OUT_PWM_EVEN] ?
						timer_pwm[2*i] : timer_out[2*i];
				end
				timer_out_pin_oe[i] <= out_q[i][`OUT_ENABLE];
			end
			key_irq <= |(key_flags & {key1_mask_q, key0_mask_q});
		end
	end
endmodule

/* File: test/key_pulse_src.sv */
// key presses and count pulses on the port pins
`timescale 1ns/1ps
module key_pulse_src (
	input wire pclk,
	output logic [3:0] key_port0,
	output logic [3:0] key_port1,
	output logic [3:0] event_pin
);
	// pins idle low: driven to 0 at time zero, before reset
	initial begin
		key_port0 = 4'h0;
		key_port1 = 4'h0;
		event_pin = 4'h0;
	end
	task press(input int i);
		{key_port1, key_port0} <= 8'h1 << i;
		repeat (4) @(posedge pclk);
		{key_port1, key_port0} <= 8'h0;
		@(posedge pclk);
	endtask
	task pulse(input int n, input int w);
		repeat (n) begin
			event_pin <= 4'hf;
			repeat (w) @(posedge pclk);
			event_pin <= 4'h0;
			repeat (8) @(posedge pclk);
		end
	endtask
endmodule

/* File: test/port_ctrl_checker.sv */
// concurrent checks on the port bank's bus and control outputs
`timescale 1ns/1ps
module port_ctrl_checker #(parameter NPAIR = 4) (
	input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire [31:0] prdata,
	input wire [NPAIR-1:0] chain_16bit, event_count_pulse, event_pin_claimed, timer_out_pin_oe,
	input wire key_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel & penable & pwrite;
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no zero wait answer");
	property p_rdy1; pready |=> !pready; endproperty
	a_rdy1: assert property (p_rdy1) else $error("ready held too long");
	property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("bad refused read");
	property p_chain; $changed(chain_16bit) |-> $past(wr) || $past(wr, 2); endproperty
	a_chain: assert property (p_chain) else $error("chain moved unasked");
	property p_claim; $changed(event_pin_claimed) |-> $past(wr) || $past(wr, 2); endproperty
	a_claim: assert property (p_claim) else $error("claim moved unasked");
	property p_oe; $changed(timer_out_pin_oe) |-> $past(wr) || $past(wr, 2); endproperty
	a_oe: assert property (p_oe) else $error("enable moved unasked");
	property p_pulse; event_count_pulse[0] |=> !event_count_pulse[0]; endproperty
	a_pulse: assert property (p_pulse) else $error("count pulse too long");
	property p_irq; $fell(key_irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3); endproperty
	a_irq: assert property (p_irq) else $error("irq dropped unasked");
endmodule

/* File: test/test_port_timer_key_irq_ctrl.sv */
// self-checking bench of the timer and key interrupt control bank
`timescale 1ns/1ps
`include "port_ctrl_defs.vh"
`define CHK(e, g, n) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module test_port_timer_key_irq_ctrl;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [17:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [7:0] tout = 0, tpwm = 0;
	wire [31:0] prdata;
	wire pready, pslverr, key_irq;
	wire [3:0] k0, k1, ev, ch, ecp, clm, pin, oe;
	int mismatches = 0, n_checks = 0, seed = 73, cnt = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (ecp[0] === 1'b1) cnt <= cnt + 1;
	port_timer_key_irq_ctrl u_port_timer_key_irq_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .key_port0(k0), .key_port1(k1),
		.event_pin(ev), .timer_out(tout), .timer_pwm(tpwm), .chain_16bit(ch),
		.event_count_pulse(ecp), .event_pin_claimed(clm), .timer_out_pin(pin),
		.timer_out_pin_oe(oe), .key_irq(key_irq));
	key_pulse_src u_src (.pclk(pclk), .key_port0(k0), .key_port1(k1), .event_pin(ev));
	task results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic w, input [15:0] off, input [31:0] d);
		int k;
		psel <= 1; pwrite <= w; paddr <= {off, 2'b00}; pwdata <= d;
		@(posedge pclk) penable <= 1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin mismatches++; results; end
		rd = prdata; er = pslverr; psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	function logic epin(input [3:0] o, input int p);
		epin = o[1] ? (o[3] ? tpwm[2*p+1] : tout[2*p+1]) : (o[2] ? tpwm[2*p] : tout[2*p]);
	endfunction
	// ****************
	// main sequence
	// ****************
	initial begin
		logic [15:0] regs[12] = '{16'hff80, 16'hff81, 16'hff90, 16'hff91, 16'hffa0, 16'hffa1,
			16'hffb0, 16'hffb1, 16'hffeb, 16'hffec, 16'hfffb, 16'hfffc};
		int em[6] = '{4, 5, 6, 7, 6, 4}, ew[6] = '{8, 8, 8, 8, 2, 2}, ee[6] = '{3, 3, 3, 3, 0, 3};
		logic [3:0] d;
		logic [15:0] fa;
		int p, c0;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (int i = 0; i < 12; i++) begin apb(0, regs[i], 0); `CHK(32'h0, rd, "reset") end
		for (int i = 0; i < 24; i++) begin
			p = $unsigned($random(seed)) % 4; d = $random(seed);
			tout <= $random(seed); tpwm <= $random(seed);
			apb(1, 16'hff80 + 16 * p + i % 2, {28'h0, d});
			apb(0, 16'hff80 + 16 * p + i % 2, 0); `CHK({28'h0, d}, rd, "cfg")
			repeat (2) @(posedge pclk);
			if (i % 2) begin `CHK(d[0], oe[p], "oe") `CHK(epin(d, p), pin[p], "pin") end
			else begin `CHK(d[3], ch[p], "chain") `CHK(d[2], clm[p], "claim") end
		end
		apb(1, 16'hff82, 1); apb(0, 16'hff82, 0); `CHK({er, rd}, 33'h100000000, "unmapped")
		apb(1, `KEY0_MASK_ADDR, 15); apb(1, `KEY1_MASK_ADDR, 15);
		for (int i = 0; i < 8; i++) begin
			fa = i < 4 ? `KEY0_FLAG_ADDR : `KEY1_FLAG_ADDR;
			u_src.press(i); apb(0, fa, 0); `CHK(32'h1 << i % 4, rd, "flag")
			`CHK(1'b1, key_irq, "irq")
			apb(1, fa, 0); apb(0, fa, 0); `CHK(32'h1 << i % 4, rd, "w0")
			apb(1, fa, 15); apb(0, fa, 0); `CHK(32'h0, rd, "w1c")
		end
		apb(1, `KEY1_MASK_ADDR, 0); u_src.press(5); repeat (3) @(posedge pclk);
		`CHK(1'b0, key_irq, "masked")
		apb(1, `KEY1_MASK_ADDR, 2); repeat (3) @(posedge pclk); `CHK(1'b1, key_irq, "unmask")
		apb(1, `KEY1_FLAG_ADDR, 2); repeat (3) @(posedge pclk); `CHK(1'b0, key_irq, "drop")
		for (int i = 0; i < 6; i++) begin
			apb(1, `PAIR0_MODE_ADDR, em[i]); c0 = cnt;
			u_src.pulse(3, ew[i]); repeat (10) @(posedge pclk);
			`CHK(ee[i], cnt - c0, "events")
		end
		results;
	end
endmodule
bind port_timer_key_irq_ctrl port_ctrl_checker #(.NPAIR(NPAIR)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .chain_16bit(chain_16bit),
	.event_count_pulse(event_count_pulse), .event_pin_claimed(event_pin_claimed),
	.timer_out_pin_oe(timer_out_pin_oe), .key_irq(key_irq));
